// file: rtl/spo_output_flow.v
`timescale 1ns/1ns
`include "spo_regs.vh"

// Notes on behaviour
// RULE_01: Present char or substitute code, strobe printer, reset sequence, preset all ones.
// RULE_02: Compare register with codes 001 and 003, qualified by decode phase.
// RULE_03: Char done flag starts transfer; next rise pulses parity check into flag.
// RULE_04: Next fall sets first phase, putting register in parallel-load mode.
// RULE_05: On parity fault force code 100 octal, set flag, load it on rise.
// RULE_06: Next fall moves to second phase; data lines driven, decoders enabled.
// RULE_07: End decode needs end code and no flagged fault; start needs start code.
// RULE_08: Strobe active low while sys clock low, printer idle, busy option on.
// RULE_09: Busy during strobe lets pulse finish, then blocks strobes until idle.
// RULE_10: No strobe while end or start decode asserted.
// RULE_11: Both phases set, then char clear resets flag, parity, loads all ones.
// RULE_12: Direct mode end decode without fault sets pending; arms reverse channel.
// RULE_13: Ring mode high count also activates reverse channel.
// RULE_14: Activation starts 200 ms hold timer; its output clears pending latch.
// RULE_15: Release only after hold expiry and busy indication cleared.
// RULE_16: Release starts 200 ms re-arm timer blocking end decode activation.
// RULE_17: Data set stops sending while reverse channel is active.
// RULE_18: Parity fault flag stays set until next start-of-message character.
// RULE_19: Parity even, odd, off, or substitute-only even and odd.
// RULE_20: Both 200 ms timers are synchronous down-counters on clk.
module spo_output_flow #(
  parameter [`SPO_TMR_W-1:0] HOLD_CYC = `SPO_HOLD_CYC,
  parameter [`SPO_TMR_W-1:0] REARM_CYC = `SPO_HOLD_CYC
) (
  input wire clk,
  input wire rst,
  input wire [`SPO_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_r,
  input wire char_valid,
  input wire [7:0] char_byte,
  output reg char_clear_r,
  input wire printer_busy_n,
  input wire buffer_high_count,
  input wire buffer_ge229,
  output reg [7:0] printer_data_r,
  output reg data_strobe_n_r,
  output reg reverse_channel_line_n_r
);

  // ----------------------------------------
  // Sequence states
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ARM = 3'h1;
  localparam [2:0] ST_PRE = 3'h2;
  localparam [2:0] ST_LOAD = 3'h3;
  localparam [2:0] ST_OUT = 3'h4;
  localparam [2:0] ST_BOTH = 3'h5;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Code compare, used for both control codes
  function code_hit;
    input [7:0] value;
    input [7:0] code;
    begin
      code_hit = (value == code);
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [5:0] ctrl_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] shreg_r;
  reg char_done_flag_r;
  reg parity_flag_r;
  reg char_fault_r;
  reg [`SPO_HALF_W-1:0] half_cnt_r;
  reg sys_clk_r;
  reg strobe_block_r;
  reg pending_r;
  reg rc_r;
  reg rc_nxt;
  reg char_parity_fault;
  reg flag_fault;
  wire sys_wrap;
  wire sys_rise;
  wire sys_fall;
  wire [2:0] pmode;
  wire busy_en;
  wire ring_mode;
  wire high_count_en;
  wire printer_busy;
  wire ones_odd;
  wire parity_check_pulse;
  wire parallel_load_pulse;
  wire char_clear;
  wire phase1;
  wire decode_phase;
  wire end_msg_decode;
  wire start_msg_decode;
  wire strobe_ok;
  wire strobe_start;
  wire busy_ind;
  wire rc_set;
  wire rc_clr;
  wire [1:0] tmr_fire;
  wire [1:0] tmr_busy;
  wire hold_busy;
  wire rearm_busy;

  assign pmode = ctrl_r[`SPO_CTRL_PMODE_HI:`SPO_CTRL_PMODE_LO];
  assign busy_en = ctrl_r[`SPO_CTRL_BUSY_EN];
  assign ring_mode = ctrl_r[`SPO_CTRL_RING];
  assign high_count_en = ctrl_r[`SPO_CTRL_HIGH_COUNT_EN];
  assign printer_busy = ~printer_busy_n;

  // ----------------------------------------
  // Printer system clock
  // ----------------------------------------
  // Derived square wave; each half lasts the 5 us strobe width
  assign sys_wrap = (half_cnt_r == `SPO_HALF_CYC - 1);
  assign sys_rise = sys_wrap & ~sys_clk_r;
  assign sys_fall = sys_wrap & sys_clk_r;

  always @(posedge clk) begin
    if (rst) begin
      half_cnt_r <= {`SPO_HALF_W{1'b0}};
      sys_clk_r <= 1'b0;
    end else if (sys_wrap) begin
      half_cnt_r <= {`SPO_HALF_W{1'b0}};
      sys_clk_r <= ~sys_clk_r;
    end else begin
      half_cnt_r <= half_cnt_r + {{(`SPO_HALF_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // Parity evaluation
  // ----------------------------------------
  // Substitute-only modes replace the char but never flag the message
  assign ones_odd = ^shreg_r;

  always @* begin
    char_parity_fault = 1'b0;
    flag_fault = 1'b0;
    case (pmode)
      `SPO_PM_EVEN: begin
        char_parity_fault = ones_odd; // [RULE_19]
        flag_fault = ones_odd;
      end
      `SPO_PM_ODD: begin
        char_parity_fault = ~ones_odd; // [RULE_19]
        flag_fault = ~ones_odd;
      end
      `SPO_PM_EVEN_SUB: begin
        char_parity_fault = ones_odd; // [RULE_19]
      end
      `SPO_PM_ODD_SUB: begin
        char_parity_fault = ~ones_odd; // [RULE_19]
      end
      default: begin
        char_parity_fault = 1'b0; // [RULE_19]
      end
    endcase
  end

  // ----------------------------------------
  // Transfer sequence
  // ----------------------------------------
  assign parity_check_pulse = (state_r == ST_ARM) & sys_rise; // [RULE_03]
  assign parallel_load_pulse = (state_r == ST_LOAD) & sys_rise & char_fault_r; // [RULE_05]
  assign char_clear = (state_r == ST_BOTH) & sys_rise; // [RULE_11]
  assign phase1 = (state_r == ST_LOAD) | (state_r == ST_BOTH);
  assign decode_phase = (state_r == ST_OUT) | (state_r == ST_BOTH);

  // Phase stepping on system clock edges: a rise, then three falls, then a rise
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (char_done_flag_r) begin
          state_nxt = ST_ARM; // [RULE_03]
        end
      end
      ST_ARM: begin
        if (sys_rise) begin
          state_nxt = ST_PRE;
        end
      end
      ST_PRE: begin
        if (sys_fall) begin
          state_nxt = ST_LOAD; // [RULE_04]
        end
      end
      ST_LOAD: begin
        if (sys_fall) begin
          state_nxt = ST_OUT; // [RULE_06]
        end
      end
      ST_OUT: begin
        if (sys_fall) begin
          state_nxt = ST_BOTH; // [RULE_11]
        end
      end
      ST_BOTH: begin
        if (sys_rise) begin
          state_nxt = ST_IDLE; // [RULE_01]
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Done flag; a new char is only accepted once the last one is cleared
  always @(posedge clk) begin
    if (rst) begin
      char_done_flag_r <= 1'b0;
    end else if (char_clear) begin
      char_done_flag_r <= 1'b0; // [RULE_11]
    end else if (char_valid && !char_done_flag_r) begin
      char_done_flag_r <= 1'b1; // [RULE_03]
    end
  end

  // Shift register: capture, substitute on fault, preset all ones on clear
  always @(posedge clk) begin
    if (rst) begin
      shreg_r <= `SPO_CODE_ONES;
    end else if (char_clear) begin
      shreg_r <= `SPO_CODE_ONES; // [RULE_01] [RULE_11]
    end else if (parallel_load_pulse && phase1) begin
      shreg_r <= `SPO_CODE_SUBST; // [RULE_05]
    end else if (char_valid && !char_done_flag_r) begin
      shreg_r <= char_byte;
    end
  end

  // Fault of the current char, caught by the parity check pulse
  always @(posedge clk) begin
    if (rst) begin
      char_fault_r <= 1'b0;
    end else if (char_clear) begin
      char_fault_r <= 1'b0; // [RULE_11]
    end else if (parity_check_pulse) begin
      char_fault_r <= char_parity_fault; // [RULE_03]
    end
  end

  // ----------------------------------------
  // Message parity flag
  // ----------------------------------------
  // Sticky across chars; set and start-code clear fall in different phases
  always @(posedge clk) begin
    if (rst) begin
      parity_flag_r <= 1'b0;
    end else if (parity_check_pulse && flag_fault) begin
      parity_flag_r <= 1'b1; // [RULE_03] [RULE_05] [RULE_18]
    end else if (start_msg_decode) begin
      parity_flag_r <= 1'b0; // [RULE_18]
    end
  end

  // ----------------------------------------
  // Control code decode
  // ----------------------------------------
  assign end_msg_decode = decode_phase & code_hit(shreg_r, `SPO_CODE_END_MSG) & ~parity_flag_r; // [RULE_02] [RULE_07]
  assign start_msg_decode = decode_phase & code_hit(shreg_r, `SPO_CODE_START_MSG); // [RULE_02] [RULE_07]

  // ----------------------------------------
  // Printer data and strobe
  // ----------------------------------------
  // Strobe may only start in the first cycle of the low half after entry
  assign strobe_ok = ~printer_busy & busy_en & ~strobe_block_r; // [RULE_08]
  assign strobe_start = (state_r == ST_OUT) & ~sys_clk_r & (half_cnt_r == {`SPO_HALF_W{1'b0}})
                        & strobe_ok & ~end_msg_decode & ~start_msg_decode; // [RULE_10]

  // Data lines settle on the entry edge, one cycle ahead of the strobe
  always @(posedge clk) begin
    if (rst) begin
      printer_data_r <= 8'h00;
    end else if ((decode_phase || (state_r == ST_LOAD && sys_fall)) && char_done_flag_r) begin
      printer_data_r <= shreg_r; // [RULE_06] [RULE_01]
    end else begin
      printer_data_r <= 8'h00;
    end
  end

  // Once started the pulse runs its full low half even if busy appears
  always @(posedge clk) begin
    if (rst) begin
      data_strobe_n_r <= 1'b1;
    end else if (strobe_start) begin
      data_strobe_n_r <= 1'b0; // [RULE_08]
    end else if (sys_rise) begin
      data_strobe_n_r <= 1'b1; // [RULE_09]
    end
  end

  // Busy seen during a strobe holds off every later strobe until it clears
  always @(posedge clk) begin
    if (rst) begin
      strobe_block_r <= 1'b0;
    end else if (!data_strobe_n_r && printer_busy) begin
      strobe_block_r <= 1'b1; // [RULE_09]
    end else if (!printer_busy) begin
      strobe_block_r <= 1'b0; // [RULE_09]
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      char_clear_r <= 1'b0;
    end else begin
      char_clear_r <= char_clear; // [RULE_11]
    end
  end

  // ----------------------------------------
  // Reverse channel
  // ----------------------------------------
  // Pending is set by end decode; the hold timer clears it, set wins
  always @(posedge clk) begin
    if (rst) begin
      pending_r <= 1'b0;
    end else if (!ring_mode && end_msg_decode) begin
      pending_r <= 1'b1; // [RULE_12]
    end else if (hold_busy) begin
      pending_r <= 1'b0; // [RULE_14]
    end
  end

  assign busy_ind = ring_mode ? buffer_ge229 : printer_busy; // [RULE_15]
  assign rc_set = (~ring_mode & pending_r & ~rearm_busy) // [RULE_12] [RULE_16]
                  | (ring_mode & high_count_en & buffer_high_count); // [RULE_13]
  assign rc_clr = ~hold_busy & ~busy_ind; // [RULE_15]

  // Hold timer is already running in the first cycle the line is active
  always @* begin
    rc_nxt = rc_r;
    if (!rc_r) begin
      rc_nxt = rc_set;
    end else if (rc_clr) begin
      rc_nxt = 1'b0;
    end
  end

  // The data set relies on this line to stop sending
  always @(posedge clk) begin
    if (rst) begin
      rc_r <= 1'b0;
      reverse_channel_line_n_r <= 1'b1;
    end else begin
      rc_r <= rc_nxt;
      reverse_channel_line_n_r <= ~rc_nxt; // [RULE_17]
    end
  end

  // Index 0 holds the line on, index 1 blocks re-arming after release
  assign tmr_fire[0] = ~rc_r & rc_nxt; // [RULE_14]
  assign tmr_fire[1] = rc_r & ~rc_nxt; // [RULE_16]
  assign hold_busy = tmr_busy[0];
  assign rearm_busy = tmr_busy[1];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_tmr
      spo_oneshot #(
        .CYCLES(gi == 0 ? HOLD_CYC : REARM_CYC)
      ) u_tmr (
        .clk(clk),
        .rst(rst),
        .fire(tmr_fire[gi]), // [RULE_20]
        .busy(tmr_busy[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      ctrl_r <= `SPO_CTRL_RESET;
    end else if (reg_wr && reg_addr == `SPO_REG_CTRL) begin
      ctrl_r <= reg_wdata[5:0];
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SPO_REG_CTRL: begin
          reg_rdata_r <= {26'h0, ctrl_r};
        end
        `SPO_REG_STATUS: begin
          reg_rdata_r <= {23'h0, strobe_block_r, rearm_busy, hold_busy, char_done_flag_r,
                          decode_phase, phase1, pending_r, rc_r, parity_flag_r};
        end
        `SPO_REG_DATA: begin
          reg_rdata_r <= {24'h0, shreg_r};
        end
        default: begin
          reg_rdata_r <= 32'h0000_0000;
        end
      endcase
    end else begin
      reg_rdata_r <= 32'h0000_0000;
    end
  end

endmodule

// file: rtl/spo_regs.vh
`ifndef SPO_REGS_VH
`define SPO_REGS_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define SPO_ADDR_W 4
`define SPO_REG_CTRL 4'h0
`define SPO_REG_STATUS 4'h4
`define SPO_REG_DATA 4'h8

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SPO_CTRL_PMODE_LO 0
`define SPO_CTRL_PMODE_HI 2
`define SPO_CTRL_BUSY_EN 3
`define SPO_CTRL_RING 4
`define SPO_CTRL_HIGH_COUNT_EN 5
`define SPO_CTRL_RESET 6'h08

// Parity modes
`define SPO_PM_EVEN 3'h0
`define SPO_PM_ODD 3'h1
`define SPO_PM_OFF 3'h2
`define SPO_PM_EVEN_SUB 3'h3
`define SPO_PM_ODD_SUB 3'h4

// ----------------------------------------
// Character codes
// ----------------------------------------
`define SPO_CODE_START_MSG 8'h01
`define SPO_CODE_END_MSG 8'h03
`define SPO_CODE_SUBST 8'h40
`define SPO_CODE_ONES 8'hff

// ----------------------------------------
// Timing
// ----------------------------------------
`define SPO_CLK_MHZ 125
`define SPO_STROBE_US 5
`define SPO_HALF_CYC (`SPO_STROBE_US * `SPO_CLK_MHZ)
`define SPO_HALF_W 10
`define SPO_HOLD_MS 200
`define SPO_HOLD_CYC (`SPO_HOLD_MS * 1000 * `SPO_CLK_MHZ)
`define SPO_TMR_W 25

`endif

// file: rtl/spo_oneshot.v
`timescale 1ns/1ns
`include "spo_regs.vh"

// Retriggerable down-counting one-shot; busy stays high for CYCLES clocks
module spo_oneshot #(
  parameter [`SPO_TMR_W-1:0] CYCLES = `SPO_HOLD_CYC
) (
  input wire clk,
  input wire rst,
  input wire fire,
  output wire busy
);

  reg [`SPO_TMR_W-1:0] count_r;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Synchronous counter instead of an RC one-shot, so the interval is exact
  always @(posedge clk) begin
    if (rst) begin
      count_r <= {`SPO_TMR_W{1'b0}};
    end else if (fire) begin
      count_r <= CYCLES;
    end else if (count_r != {`SPO_TMR_W{1'b0}}) begin
      count_r <= count_r - {{(`SPO_TMR_W-1){1'b0}}, 1'b1};
    end
  end

  assign busy = (count_r != {`SPO_TMR_W{1'b0}});

endmodule

// file: dv/spo_output_flow_chk.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port checker
// ----------------------------------------
module spo_output_flow_chk #(
  parameter [24:0] HOLD_CYC = 25'h0c8,
  parameter [24:0] REARM_CYC = 25'h0c8
) (
  input wire clk,
  input wire rst,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata_r,
  input wire char_valid,
  input wire [7:0] char_byte,
  input wire char_clear_r,
  input wire printer_busy_n,
  input wire buffer_high_count,
  input wire buffer_ge229,
  input wire [7:0] printer_data_r,
  input wire data_strobe_n_r,
  input wire reverse_channel_line_n_r
);
  reg [9:0] stb_cnt_r;
  reg [24:0] low_cnt_r;
  reg [24:0] high_cnt_r;
  // Lengths of strobe and reverse channel phases; high time saturates so reset counts as idle
  always @(posedge clk) begin
    if (rst) begin
      stb_cnt_r <= 10'h000;
      low_cnt_r <= 25'h0;
      high_cnt_r <= REARM_CYC;
    end else begin
      stb_cnt_r <= data_strobe_n_r ? 10'h000 : stb_cnt_r + 10'h001;
      low_cnt_r <= reverse_channel_line_n_r ? 25'h0 : low_cnt_r + 25'h1;
      if (!reverse_channel_line_n_r)
        high_cnt_r <= 25'h0;
      else if (high_cnt_r < REARM_CYC)
        high_cnt_r <= high_cnt_r + 25'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_clear_one_cycle: assert property (char_clear_r |=> !char_clear_r)
    else $error("char clear wider than one cycle");
  a_strobe_full_width: assert property ($rose(data_strobe_n_r) |-> stb_cnt_r == 10'h270)
    else $error("strobe width wrong");
  a_no_start_strobe: assert property ($fell(data_strobe_n_r) |-> printer_data_r != 8'h01)
    else $error("start code strobed");
  a_strobe_printer_idle: assert property ($fell(data_strobe_n_r) |-> $past(printer_busy_n))
    else $error("strobe while printer busy");
  a_data_steady_strobe: assert property (!data_strobe_n_r |-> $stable(printer_data_r))
    else $error("data moved under strobe");
  a_hold_minimum: assert property ($rose(reverse_channel_line_n_r) |-> low_cnt_r >= HOLD_CYC)
    else $error("reverse channel released early");
  a_release_when_idle: assert property ($rose(reverse_channel_line_n_r) |-> $past(printer_busy_n) || !$past(buffer_ge229))
    else $error("reverse channel released while busy");
  a_rearm_gap: assert property ($fell(reverse_channel_line_n_r) && !$past(buffer_high_count) |-> high_cnt_r >= REARM_CYC)
    else $error("reverse channel rearmed early");
  c_strobe: cover property ($fell(data_strobe_n_r));
  c_rev_chan: cover property ($fell(reverse_channel_line_n_r));
  c_clear: cover property (char_clear_r);
endmodule
bind spo_output_flow spo_output_flow_chk #(.HOLD_CYC(HOLD_CYC), .REARM_CYC(REARM_CYC)) chk_i (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_r(reg_rdata_r), .char_valid(char_valid), .char_byte(char_byte), .char_clear_r(char_clear_r),
  .printer_busy_n(printer_busy_n), .buffer_high_count(buffer_high_count), .buffer_ge229(buffer_ge229),
  .printer_data_r(printer_data_r), .data_strobe_n_r(data_strobe_n_r),
  .reverse_channel_line_n_r(reverse_channel_line_n_r));

// file: dv/spo_printer_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Printer on the parallel side
// ----------------------------------------
module spo_printer_model (
  input wire clk,
  input wire rst,
  input wire [7:0] printer_data_r,
  input wire data_strobe_n_r,
  input wire slow,
  input wire force_busy,
  output wire printer_busy_n,
  output reg [7:0] last_data_r,
  output reg [7:0] strobe_count_r
);
  reg busy_r;
  reg [3:0] low_cnt_r;
  // Latch data at strobe start; a slow printer turns busy mid strobe and stays busy
  always @(posedge clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      low_cnt_r <= 4'h0;
      last_data_r <= 8'h00;
      strobe_count_r <= 8'h00;
    end else if (!data_strobe_n_r) begin
      if (low_cnt_r == 4'h0) begin
        last_data_r <= printer_data_r;
        strobe_count_r <= strobe_count_r + 8'h01;
      end
      if (low_cnt_r != 4'hf)
        low_cnt_r <= low_cnt_r + 4'h1;
      if (slow && low_cnt_r == 4'ha)
        busy_r <= 1'b1;
    end else begin
      low_cnt_r <= 4'h0;
      if (!slow)
        busy_r <= 1'b0;
    end
  end
  assign printer_busy_n = !(busy_r | force_busy);
endmodule

// file: dv/spo_output_flow_tb_top.sv
`timescale 1ns/1ns
`include "spo_regs.vh"
// ----------------------------------------
// Bench top
// ----------------------------------------
module spo_output_flow_tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg char_valid = 1'b0;
  reg [7:0] char_byte = 8'h00;
  reg buffer_high_count = 1'b0;
  reg buffer_ge229 = 1'b0;
  reg slow = 1'b0;
  reg force_busy = 1'b0;
  wire [31:0] reg_rdata_r;
  wire char_clear_r;
  wire printer_busy_n;
  wire [7:0] printer_data_r;
  wire data_strobe_n_r;
  wire reverse_channel_line_n_r;
  wire [7:0] last_data_r;
  wire [7:0] strobe_count_r;
  integer n_errors = 0;
  integer check_count = 0;
  integer i;
  reg [7:0] cnt0;
  reg [31:0] tab [0:3];
  // Short timers keep the run brief; hold must outlast the decode phases or pending survives it
  spo_output_flow #(.HOLD_CYC(25'h7d0), .REARM_CYC(25'h7d0)) dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .char_valid(char_valid), .char_byte(char_byte), .char_clear_r(char_clear_r),
    .printer_busy_n(printer_busy_n), .buffer_high_count(buffer_high_count), .buffer_ge229(buffer_ge229),
    .printer_data_r(printer_data_r), .data_strobe_n_r(data_strobe_n_r),
    .reverse_channel_line_n_r(reverse_channel_line_n_r));
  spo_printer_model prn (
    .clk(clk), .rst(rst), .printer_data_r(printer_data_r), .data_strobe_n_r(data_strobe_n_r),
    .slow(slow), .force_busy(force_busy), .printer_busy_n(printer_busy_n),
    .last_data_r(last_data_r), .strobe_count_r(strobe_count_r));
  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end
  task chk(input string name, input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (n_errors == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input [3:0] a, input [31:0] m, input [31:0] exp, input string name);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(name, reg_rdata_r & m, exp);
    end
  endtask
  task wait_line(input v, input integer lim);
    integer k;
    begin
      k = 0;
      while (reverse_channel_line_n_r !== v && k < lim) begin
        @(posedge clk);
        k = k + 1;
      end
      if (reverse_channel_line_n_r !== v) begin
        chk("rev chan wait", 32'h0, 32'h1);
        report_and_stop;
      end
    end
  endtask
  // One character through the sequencer; expects n strobes carrying d
  task send(input [7:0] b, input [7:0] n, input [7:0] d);
    integer k;
    begin
      wait_line(1'b1, 20000);
      cnt0 = strobe_count_r;
      @(posedge clk);
      char_byte <= b;
      char_valid <= 1'b1;
      @(posedge clk);
      char_valid <= 1'b0;
      k = 0;
      while (char_clear_r !== 1'b1 && k < 6000) begin
        @(posedge clk);
        k = k + 1;
      end
      if (char_clear_r !== 1'b1) begin
        chk("clear wait", 32'h0, 32'h1);
        report_and_stop;
      end
      repeat (3) @(posedge clk);
      chk("pdata idle", {24'h0, printer_data_r}, 32'h0);
      chk("strobes", strobe_count_r - cnt0, n);
      if (n != 8'h00)
        chk("pdata", last_data_r, d);
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tab[0] = 32'h02434300;
    tab[1] = 32'h03434000;
    tab[2] = 32'h04414000;
    tab[3] = 32'h01414001;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(`SPO_REG_CTRL, 32'hffffffff, 32'h8, "ctrl");
    rd(4'hc, 32'hffffffff, 32'h0, "unmapped");
    wr(`SPO_REG_STATUS, 32'hffffffff);
    wr(`SPO_REG_CTRL, 32'hffffffc8);
    rd(`SPO_REG_STATUS, 32'hffffffff, 32'h0, "status");
    rd(`SPO_REG_CTRL, 32'hffffffff, 32'h8, "ctrl");
    send(8'h41, 8'h01, 8'h41);
    rd(`SPO_REG_DATA, 32'hff, 32'hff, "data");
    send(8'h43, 8'h01, 8'h40);
    rd(`SPO_REG_STATUS, 32'h1, 32'h1, "flag");
    send(8'h03, 8'h01, 8'h03);
    chk("rev chan", reverse_channel_line_n_r, 1'b1);
    wr(`SPO_REG_CTRL, 32'h9);
    send(8'h01, 8'h00, 8'h00);
    rd(`SPO_REG_STATUS, 32'h1, 32'h0, "flag");
    wr(`SPO_REG_CTRL, 32'h8);
    slow <= 1'b1;
    send(8'h41, 8'h01, 8'h41);
    send(8'h41, 8'h00, 8'h00);
    slow <= 1'b0;
    wr(`SPO_REG_CTRL, 32'h0);
    send(8'h41, 8'h00, 8'h00);
    wr(`SPO_REG_CTRL, 32'h8);
    force_busy <= 1'b1;
    send(8'h03, 8'h00, 8'h00);
    wait_line(1'b0, 10);
    repeat (2100) @(posedge clk);
    chk("rev chan busy", reverse_channel_line_n_r, 1'b0);
    force_busy <= 1'b0;
    wait_line(1'b1, 10);
    rd(`SPO_REG_STATUS, 32'h80, 32'h80, "rearm");
    for (i = 0; i < 4; i = i + 1) begin
      wr(`SPO_REG_CTRL, {29'h1, tab[i][26:24]});
      send(tab[i][23:16], 8'h01, tab[i][15:8]);
      rd(`SPO_REG_STATUS, 32'h1, {24'h0, tab[i][7:0]}, "mode flag");
    end
    wr(`SPO_REG_CTRL, 32'h30);
    buffer_high_count <= 1'b1;
    wait_line(1'b0, 10);
    buffer_high_count <= 1'b0;
    buffer_ge229 <= 1'b1;
    repeat (2100) @(posedge clk);
    chk("rev chan ring", reverse_channel_line_n_r, 1'b0);
    buffer_ge229 <= 1'b0;
    wait_line(1'b1, 10);
    report_and_stop;
  end
endmodule
